//--- dv/otpp_prog_model.sv
`timescale 1ns/1ns
module otpp_prog_model (
    input wire logic i_clk,
    input wire logic i_dev_oe,
    input wire logic [7:0] i_dev_byte,
    output logic o_cs_n,
    output logic o_oe_n,
    output logic [1:0] o_mode,
    output logic o_clear,
    output logic o_aclk,
    output logic o_strobe_n,
    output logic [7:0] o_bus
);
    logic [7:0] drv_q = 8'h00;
    // Pin levels: cs_n, oe_n, mode, clear, aclk, strobe_n
    logic [6:0] pin_q = 7'h61;
    assign {o_cs_n, o_oe_n, o_mode, o_clear, o_aclk, o_strobe_n} = pin_q;
    // ****************************************
    // Byte lines: device, programmer, or churn
    // ****************************************
    assign o_bus = i_dev_oe ? i_dev_byte : (o_oe_n ? drv_q : ~drv_q);
    task automatic tick(input int n);
        repeat (n) @(negedge i_clk);
    endtask : tick
    task automatic pins(input logic cs_n, input logic oe_n,
                        input logic [1:0] m);
        pin_q[6] = cs_n;
        pin_q[5] = oe_n;
        pin_q[4:3] = m;
        tick(6);
    endtask : pins
    task automatic clear_addr();
        pin_q[2] = 1'b1;
        tick(4);
        pin_q[2] = 1'b0;
        tick(4);
    endtask : clear_addr
    task automatic step_addr();
        pin_q[1] = 1'b1;
        tick(4);
        pin_q[1] = 1'b0;
        tick(4);
    endtask : step_addr
    task automatic strobe(input logic [7:0] d);
        drv_q = d;
        tick(1);
        pin_q[0] = 1'b0;
        tick(4);
        pin_q[0] = 1'b1;
        tick(8);
    endtask : strobe
endmodule : otpp_prog_model

//--- dv/tb_top.sv
`timescale 1ns/1ns
module tb_top;
    import otpp_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    int err_count = 0;
    int num_checks = 0;
    logic cs_n, oe_n, clr, aclk, stb_n, oe, prot, lown, full;
    logic [1:0] mode;
    logic [7:0] bus, dout;
    logic [7:0] pat [4] = '{8'hA5, 8'h3C, 8'hFF, 8'h00};
    always #20 clk = ~clk;
    otpp_port #(.MEM_BYTES(MEM_BYTES_DEF)) i_dut (.i_clk(clk),
        .i_rst_b(rst_b), .i_chip_sel_n(cs_n), .i_out_drive_n(oe_n),
        .i_program_mode_select(mode), .i_clear(clr), .i_addr_clk(aclk),
        .i_write_strobe_n(stb_n), .i_byte_lines(bus), .o_byte_lines(dout),
        .o_byte_lines_oe(oe), .o_protect(prot), .o_low_noise(lown),
        .o_buf_full(full));
    otpp_prog_model i_prog (.i_clk(clk), .i_dev_oe(oe), .i_dev_byte(dout),
        .o_cs_n(cs_n), .o_oe_n(oe_n), .o_mode(mode), .o_clear(clr),
        .o_aclk(aclk), .o_strobe_n(stb_n), .o_bus(bus));
    // ****************************************
    // Shared helpers
    // ****************************************
    task automatic check(input string nm, input logic [7:0] exp,
                         input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask : check
    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : conclude
    task automatic do_reset();
        rst_b = 1'b0;
        i_prog.tick(6);
        rst_b = 1'b1;
        i_prog.tick(3);
    endtask : do_reset
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        check("oe", 8'h00, {7'h00, oe});
        check("fuses", 8'h00, {6'h00, lown, prot});
        check("full", 8'h00, {7'h00, full});
        check("dout", 8'h00, dout);
    endtask : t_reset
    task automatic t_program();
        i_prog.pins(1'b0, 1'b1, OTPP_MODE_PROGRAM);
        i_prog.clear_addr();
        for (int i = 0; i < 4; i++) begin
            i_prog.strobe(pat[i]);
            i_prog.step_addr();
        end
        check("full", 8'h00, {7'h00, full});
    endtask : t_program
    task automatic t_read(input logic [1:0] m);
        i_prog.pins(1'b0, 1'b0, m);
        i_prog.clear_addr();
        for (int i = 0; i < 4; i++) begin
            check("oe", 8'h01, {7'h00, oe});
            check("rdata", pat[i], bus);
            i_prog.step_addr();
        end
        i_prog.pins(1'b0, 1'b1, m);
        check("oe off", 8'h00, {7'h00, oe});
    endtask : t_read
    task automatic t_deselect();
        i_prog.pins(1'b0, 1'b1, OTPP_MODE_PROGRAM);
        i_prog.clear_addr();
        i_prog.pins(1'b1, 1'b1, OTPP_MODE_PROGRAM);
        i_prog.strobe(8'h77);
        i_prog.pins(1'b1, 1'b0, OTPP_MODE_READ);
        check("oe desel", 8'h00, {7'h00, oe});
        i_prog.pins(1'b0, 1'b0, OTPP_MODE_READ);
        check("kept", pat[0], bus);
    endtask : t_deselect
    task automatic t_options();
        i_prog.pins(1'b0, 1'b1, OTPP_MODE_OPTION);
        i_prog.strobe(8'h02);
        check("noise only", 8'h02, {6'h00, lown, prot});
        do_reset();
        i_prog.pins(1'b0, 1'b1, OTPP_MODE_OPTION);
        i_prog.strobe(8'h01);
        check("protect", 8'h03, {6'h00, lown, prot});
        i_prog.pins(1'b0, 1'b0, OTPP_MODE_READ);
        check("prot read", PROT_READ_VAL, bus);
    endtask : t_options
    initial begin
        #400000;
        err_count++;
        conclude();
    end
    initial begin
        i_prog.tick(6);
        rst_b = 1'b1;
        i_prog.tick(3);
        t_reset();
        t_program();
        t_read(OTPP_MODE_READ);
        t_read(OTPP_MODE_VERIFY);
        t_deselect();
        t_options();
        conclude();
    end
endmodule : tb_top

//--- rtl/otpp_fifo.sv
`timescale 1ns/1ns
module otpp_fifo
    import otpp_pkg::*;
#(
    parameter int W = 19,
    parameter int DEPTH = FIFO_DEPTH_DEF
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    otpp_fifo_if.fifo f
);
    localparam int PW = $clog2(DEPTH);
    // ****************************************
    // Parameter check
    // ****************************************
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("otpp_fifo: DEPTH must be a power of two");
    end
    // ****************************************
    // Storage and pointers
    // ****************************************
    logic [W-1:0] mem_q [DEPTH];
    logic [PW:0] wp_q;
    logic [PW:0] rp_q;
    wire full_w = (wp_q[PW] != rp_q[PW]) && (wp_q[PW-1:0] == rp_q[PW-1:0]);
    wire empty_w = (wp_q == rp_q);
    wire push_w = f.in_valid && !full_w;
    wire pop_w = f.out_ready && !empty_w;
    assign f.in_ready = !full_w;
    assign f.out_valid = !empty_w;
    assign f.out_data = mem_q[rp_q[PW-1:0]];
    always_ff @(posedge i_clk) begin
        if (push_w) begin
            mem_q[wp_q[PW-1:0]] <= f.in_data;
        end
    end
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            wp_q <= '0;
            rp_q <= '0;
        end else begin
            wp_q <= wp_q + (PW+1)'(push_w);
            rp_q <= rp_q + (PW+1)'(pop_w);
        end
    end
endmodule : otpp_fifo

//--- rtl/otpp_fifo_if.sv
`timescale 1ns/1ns
interface otpp_fifo_if #(parameter int W = 19);
    logic in_valid;
    logic in_ready;
    logic [W-1:0] in_data;
    logic out_valid;
    logic out_ready;
    logic [W-1:0] out_data;
    modport fifo (input in_valid, input in_data, input out_ready,
                  output in_ready, output out_valid, output out_data);
    modport user (output in_valid, output in_data, output out_ready,
                  input in_ready, input out_valid, input out_data);
endinterface : otpp_fifo_if

//--- rtl/otpp_pkg.sv
package otpp_pkg;
    // ****************************************
    // Sizes
    // ****************************************
    localparam int MEM_BYTES_DEF = 2048;
    localparam int MEM_BYTES_ALT = 1024;
    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH_DEF = 16;
    // ****************************************
    // Sub-mode codes on the mode-select pins
    // ****************************************
    typedef enum logic [1:0] {
        OTPP_MODE_READ = 2'h0,
        OTPP_MODE_PROGRAM = 2'h1,
        OTPP_MODE_VERIFY = 2'h2,
        OTPP_MODE_OPTION = 2'h3
    } otpp_mode_type;
    // ****************************************
    // Option byte fields and reset values
    // ****************************************
    localparam int OPT_PROT_BIT = 0;
    localparam int OPT_NOISE_BIT = 1;
    localparam logic [7:0] PROT_READ_VAL = 8'hFF;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    // Synchroniser reset: cs_n, oe_n, mode, clear, aclk, strobe_n, data
    localparam int SYNC_W = 15;
    localparam logic [14:0] SYNC_RST = 15'h6100;
endpackage : otpp_pkg

//--- rtl/otpp_port.sv
// Contract
// - Memory holds 1K or 2K bytes depending on variant.
// - Bytes move both ways over the eight bidirectional byte lines.
// - Output-drive low drives byte lines out while chip select is low; high makes them inputs.
// - Clear high holds the address counter at location zero.
// - Each address clock cycle with clear low advances the counter by exactly one.
// - Write strobe low programs the byte on the lines; data held valid.
// - Mode-select level picks read, program, program verify or option programming.
// - Programming protect also forces the low-noise option on.
// - Programming low-noise alone leaves protect unselected.
`timescale 1ns/1ns
module otpp_port
    import otpp_pkg::*;
#(
    parameter int MEM_BYTES = MEM_BYTES_DEF
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_chip_sel_n,
    input wire logic i_out_drive_n,
    input wire logic [1:0] i_program_mode_select,
    input wire logic i_clear,
    input wire logic i_addr_clk,
    input wire logic i_write_strobe_n,
    input wire logic [7:0] i_byte_lines,
    output logic [7:0] o_byte_lines,
    output logic o_byte_lines_oe,
    output logic o_protect,
    output logic o_low_noise,
    output logic o_buf_full
);
    localparam int AW = $clog2(MEM_BYTES);
    localparam int FW = AW + DATA_W;
    // ****************************************
    // Parameter check
    // ****************************************
    if (MEM_BYTES != MEM_BYTES_DEF && MEM_BYTES != MEM_BYTES_ALT)
    begin : g_bad_size
        $error("otpp_port: MEM_BYTES must be 1024 or 2048");
    end
    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [SYNC_W-1:0] meta_q;
    logic [SYNC_W-1:0] sync_q;
    logic aclk_prev_q;
    logic strobe_prev_q;
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            meta_q <= SYNC_RST;
            sync_q <= SYNC_RST;
        end else begin
            meta_q <= {i_chip_sel_n, i_out_drive_n, i_program_mode_select,
                       i_clear, i_addr_clk, i_write_strobe_n, i_byte_lines};
            sync_q <= meta_q;
        end
    end
    wire cs_n_s = sync_q[14];
    wire oe_n_s = sync_q[13];
    wire [1:0] mode_s = sync_q[12:11];
    wire clr_s = sync_q[10];
    wire aclk_s = sync_q[9];
    wire strobe_n_s = sync_q[8];
    wire [7:0] din_s = sync_q[7:0];
    // ****************************************
    // Decode
    // ****************************************
    wire sel_w = !cs_n_s;
    wire mode_prog_w = (mode_s == OTPP_MODE_PROGRAM);
    wire mode_rd_w = (mode_s == OTPP_MODE_READ) ||
                     (mode_s == OTPP_MODE_VERIFY);
    wire mode_opt_w = (mode_s == OTPP_MODE_OPTION);
    wire aclk_rise_w = aclk_s && !aclk_prev_q;
    wire strobe_fall_w = !strobe_n_s && strobe_prev_q;
    wire drive_w = sel_w && !oe_n_s;
    wire push_w = sel_w && oe_n_s && mode_prog_w && strobe_fall_w;
    wire opt_w = sel_w && oe_n_s && mode_opt_w && strobe_fall_w;
    // ****************************************
    // Address counter
    // ****************************************
    logic [AW-1:0] addr_q;
    logic [AW-1:0] addr_d;
    assign addr_d = clr_s ? '0 :
                    aclk_rise_w ? addr_q + AW'(1) : addr_q;
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            addr_q <= '0;
            aclk_prev_q <= 1'b0;
            strobe_prev_q <= 1'b1;
        end else begin
            addr_q <= addr_d;
            aclk_prev_q <= aclk_s;
            strobe_prev_q <= strobe_n_s;
        end
    end
    // ****************************************
    // Program buffer and memory array
    // ****************************************
    otpp_fifo_if #(.W(FW)) fq ();
    assign fq.in_valid = push_w;
    assign fq.in_data = {addr_q, din_s};
    assign fq.out_ready = !o_byte_lines_oe;
    otpp_fifo #(.W(FW), .DEPTH(FIFO_DEPTH_DEF)) u_fifo (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .f(fq.fifo)
    );
    logic [7:0] mem_q [MEM_BYTES];
    wire wr_en_w = fq.out_valid && fq.out_ready;
    wire [AW-1:0] wr_addr_w = fq.out_data[FW-1:DATA_W];
    always_ff @(posedge i_clk) begin
        if (wr_en_w) begin
            mem_q[wr_addr_w] <= fq.out_data[DATA_W-1:0];
        end
    end
    // ****************************************
    // Option fuses
    // ****************************************
    wire prot_d = o_protect || (opt_w && din_s[OPT_PROT_BIT]);
    wire noise_d = o_low_noise || (opt_w && (din_s[OPT_NOISE_BIT] ||
                   din_s[OPT_PROT_BIT]));
    // ****************************************
    // Read-back and drive
    // ****************************************
    wire [7:0] rd_val_w = o_protect ? PROT_READ_VAL : mem_q[addr_q];
    always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
            o_byte_lines <= BYTE_ZERO;
            o_byte_lines_oe <= 1'b0;
            o_protect <= 1'b0;
            o_low_noise <= 1'b0;
            o_buf_full <= 1'b0;
        end else begin
            if (mode_rd_w) begin
                o_byte_lines <= rd_val_w;
            end
            o_byte_lines_oe <= drive_w;
            o_protect <= prot_d;
            o_low_noise <= noise_d;
            o_buf_full <= !fq.in_ready;
        end
    end
    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    AST_DRIVE_ON: assert property (
        (!oe_n_s && !cs_n_s) |=> o_byte_lines_oe)
        else $error("byte lines not driven while output drive low");
    AST_DRIVE_OFF: assert property (
        oe_n_s |=> !o_byte_lines_oe)
        else $error("byte lines driven while output drive high");
    AST_CS_IGNORE: assert property (
        cs_n_s |=> !o_byte_lines_oe && $stable(o_protect) && !$past(push_w))
        else $error("port acted while chip select high");
    AST_CLEAR: assert property (
        clr_s [*2] |=> addr_q == '0)
        else $error("address counter not held at zero by clear");
    AST_STEP: assert property (
        (aclk_rise_w && !clr_s) |=> addr_q == $past(addr_q) + AW'(1))
        else $error("address counter did not step by one");
    AST_HOLD: assert property (
        (!aclk_rise_w && !clr_s) |=> $stable(addr_q))
        else $error("address counter moved without a clock");
    AST_PROG: assert property (
        (sel_w && oe_n_s && mode_prog_w && strobe_fall_w && fq.in_ready)
        |=> fq.out_valid)
        else $error("program strobe did not queue a byte");
    AST_PROT_NOISE: assert property (
        o_protect |-> o_low_noise)
        else $error("protect set without low noise");
    AST_NOISE_ALONE: assert property (
        (opt_w && !din_s[OPT_PROT_BIT] && !o_protect)
        |=> !o_protect && o_low_noise == $past(noise_d))
        else $error("low noise alone changed protect");
    AST_READ: assert property (
        (mode_rd_w && o_protect) |=> o_byte_lines == PROT_READ_VAL)
        else $error("protected read did not return fill value");
endmodule : otpp_port
